/* hw/dcs_arb.sv */
`default_nettype none
module dcs_arb (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Requests, bit 0 is channel 1
    input  wire logic [1:0] req,
    // Registered grant
    output var  logic       gnt_valid,
    output var  logic       gnt_ch
);
    typedef struct packed {
        logic valid;
        logic ch;
    } dcs_arb_st_t;

    dcs_arb_st_t s_r;
    dcs_arb_st_t s_nxt;

    always_comb begin
        s_nxt.valid = |req;
        s_nxt.ch    = !req[0];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gnt_valid = s_r.valid;
    assign gnt_ch    = s_r.ch;

endmodule
`default_nettype wire

/* hw/dcs_fifo.sv */
`default_nettype none
module dcs_fifo #(
    parameter int W = 31,
    parameter int D = 8
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output var  logic         in_ready,
    // Drain side
    output var  logic         out_valid,
    output var  logic [W-1:0] out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          ov;
        logic [W-1:0]  od;
    } dcs_fifo_st_t;

    dcs_fifo_st_t s_r;
    dcs_fifo_st_t s_nxt;
    logic [W-1:0] mem [D];
    logic         push;
    logic         load;

    // Output word sits in a register so the drain sees a clean flop
    always_comb begin
        s_nxt    = s_r;
        in_ready = s_r.cnt != (AW+1)'(D);
        push     = in_valid && in_ready;
        load     = (!s_r.ov || out_ready) && s_r.cnt != '0;
        if (load) begin
            s_nxt.od = mem[s_r.rp];
            s_nxt.ov = 1'b1;
            s_nxt.rp = s_r.rp + 1'b1;
        end else if (out_ready) begin
            s_nxt.ov = 1'b0;
        end
        if (push) begin
            s_nxt.wp = s_r.wp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[s_r.wp] <= in_data;
        end
    end

    assign out_valid = s_r.ov;
    assign out_data  = s_r.od;

endmodule
`default_nettype wire

/* hw/dcs_pkg.sv */
`default_nettype none
package dcs_pkg;

    localparam int WORD_W   = 16;
    localparam int SC_W     = 6;
    localparam int ADDR_W   = 15;
    localparam int N_CH     = 2;
    localparam int FIFO_DEPTH = 8;

    // Select codes served by the two channels
    localparam logic [SC_W-1:0] SC_SETUP_CH1 = 6'h02;
    localparam logic [SC_W-1:0] SC_SETUP_CH2 = 6'h03;
    localparam logic [SC_W-1:0] SC_CTRL_CH1  = 6'h06;
    localparam logic [SC_W-1:0] SC_CTRL_CH2  = 6'h07;

    // Field positions of the control words
    localparam int ASSIGN_SC_LSB    = 0;
    localparam int ASSIGN_CLC_BIT   = 13;
    localparam int ASSIGN_STC_BIT   = 15;
    localparam int ADDR_DIR_BIT     = 15;
    localparam int ADDR_LSB         = 0;

    // Completion interrupt locations
    localparam logic [WORD_W-1:0] IRQ_LOC_CH1 = 16'h0006;
    localparam logic [WORD_W-1:0] IRQ_LOC_CH2 = 16'h0007;

    // Count value that marks the last word of a block
    localparam logic [WORD_W-1:0] COUNT_LAST = 16'hffff;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_OUTPUT_ACC,
        OP_LOAD_INPUT_ACC,
        OP_SET_CONTROL,
        OP_CLEAR_CONTROL,
        OP_SET_FLAG,
        OP_CLEAR_FLAG,
        OP_SKIP_FLAG_SET
    } dcs_io_op_t;

    typedef struct packed {
        logic              strobe;
        dcs_io_op_t        op;
        logic [SC_W-1:0]   sc;
        logic              clr_flag;
        logic [WORD_W-1:0] wdata;
    } dcs_io_req_t;

    typedef struct packed {
        logic              valid;
        logic [WORD_W-1:0] rdata;
        logic              flag;
    } dcs_io_resp_t;

    typedef struct packed {
        logic            valid;
        logic [SC_W-1:0] sc;
        logic            set_control;
        logic            clear_flag;
        logic            clear_control;
    } dcs_per_cmd_t;

    typedef struct packed {
        logic              sel;
        logic              wr;
        logic [SC_W-1:0]   sc;
        logic [WORD_W-1:0] data;
    } dcs_per_out_t;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } dcs_mem_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } dcs_wr_word_t;

    typedef struct packed {
        logic [SC_W-1:0]   sc;
        logic              opt_stc;
        logic              opt_clc;
        logic              dir_in;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] count;
        logic              route_count;
        logic              active;
        logic              ctl;
        logic              flag;
    } dcs_chan_t;

endpackage
`default_nettype wire

/* hw/dcs_top.sv */
`default_nettype none
module dcs_top (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Processor I/O instruction path
    input  wire dcs_pkg::dcs_io_req_t  io_req,
    output var  dcs_pkg::dcs_io_resp_t io_resp,
    // Completion interrupts
    output var  logic [1:0]            irq_req,
    output var  logic [15:0]           irq_loc,
    // Interface cards
    input  wire logic [63:0]           per_flag,
    input  wire logic [15:0]           per_din,
    output var  dcs_pkg::dcs_per_out_t per_out,
    output var  dcs_pkg::dcs_per_cmd_t per_cmd,
    // Memory port
    output var  dcs_pkg::dcs_mem_req_t mem_req,
    input  wire logic                  mem_gnt,
    input  wire logic                  mem_rvalid,
    input  wire logic [15:0]           mem_rdata
);
    typedef enum logic [2:0] {
        E_IDLE,
        E_SEL,
        E_CAP,
        E_MRD,
        E_MWAIT,
        E_CMD,
        E_GAP
    } dcs_eng_t;

    typedef struct packed {
        dcs_pkg::dcs_chan_t [1:0] chan;
        dcs_eng_t                 eng;
        logic                     cur;
        logic                     rd_issued;
        dcs_pkg::dcs_io_resp_t    io_resp;
        dcs_pkg::dcs_per_out_t    per_out;
        dcs_pkg::dcs_per_cmd_t    per_cmd;
        dcs_pkg::dcs_mem_req_t    mem;
        logic [1:0]               irq;
        logic [15:0]              irq_loc;
    } dcs_state_t;

    dcs_state_t             s_r;
    dcs_state_t             s_nxt;
    logic [1:0]             req;
    logic                   gnt_valid;
    logic                   gnt_ch;
    logic                   fifo_in_valid;
    logic                   fifo_in_ready;
    dcs_pkg::dcs_wr_word_t  fifo_in_data;
    logic                   fifo_out_valid;
    logic                   fifo_out_ready;
    dcs_pkg::dcs_wr_word_t  fifo_out_data;

    // Setup code of a channel, ch 0 is channel 1
    function automatic logic [5:0] setup_sc(input logic ch);
        setup_sc = ch ? dcs_pkg::SC_SETUP_CH2 : dcs_pkg::SC_SETUP_CH1;
    endfunction

    function automatic logic [5:0] ctrl_sc(input logic ch);
        ctrl_sc = ch ? dcs_pkg::SC_CTRL_CH2 : dcs_pkg::SC_CTRL_CH1;
    endfunction

    // A card flag pulls a channel in whatever its interrupt priority
    always_comb begin
        for (int c = 0; c < dcs_pkg::N_CH; c++) begin
            req[c] = s_r.chan[c].active && per_flag[s_r.chan[c].sc]
                     && s_r.eng == E_IDLE;
        end
    end

    dcs_arb u_arb (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .req       (req),
        .gnt_valid (gnt_valid),
        .gnt_ch    (gnt_ch)
    );

    dcs_fifo #(
        .W ($bits(dcs_pkg::dcs_wr_word_t)),
        .D (dcs_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_data   (fifo_in_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_out_ready)
    );

    always_comb begin
        fifo_in_valid     = s_r.eng == E_CAP && s_r.chan[s_r.cur].dir_in;
        fifo_in_data.addr = s_r.chan[s_r.cur].addr;
        fifo_in_data.data = per_din;
    end

    always_comb begin
        logic               c;
        logic               last;
        dcs_pkg::dcs_chan_t ch;
        c              = 1'b0;
        last           = 1'b0;
        ch             = '0;
        s_nxt          = s_r;
        fifo_out_ready = 1'b0;
        s_nxt.io_resp.valid  = 1'b0;
        s_nxt.per_cmd.valid  = 1'b0;
        s_nxt.per_out.wr     = 1'b0;

        // Processor instructions addressed to the channel select codes
        if (io_req.strobe) begin
            s_nxt.io_resp.valid = 1'b1;
            s_nxt.io_resp.rdata = '0;
            s_nxt.io_resp.flag  = 1'b0;
            for (int k = 0; k < dcs_pkg::N_CH; k++) begin
                if (io_req.sc == setup_sc(k[0])) begin
                    case (io_req.op)
                        dcs_pkg::OP_CLEAR_CONTROL: s_nxt.chan[k].route_count = 1'b0;
                        dcs_pkg::OP_SET_CONTROL:   s_nxt.chan[k].route_count = 1'b1;
                        dcs_pkg::OP_OUTPUT_ACC: begin
                            if (s_r.chan[k].route_count) begin
                                s_nxt.chan[k].count = io_req.wdata;
                            end else begin
                                s_nxt.chan[k].dir_in = io_req.wdata[dcs_pkg::ADDR_DIR_BIT];
                                s_nxt.chan[k].addr   =
                                    io_req.wdata[dcs_pkg::ADDR_LSB +: dcs_pkg::ADDR_W];
                            end
                        end
                        dcs_pkg::OP_LOAD_INPUT_ACC: s_nxt.io_resp.rdata = s_r.chan[k].count;
                        default: ;
                    endcase
                end
                if (io_req.sc == ctrl_sc(k[0])) begin
                    case (io_req.op)
                        dcs_pkg::OP_OUTPUT_ACC: begin
                            s_nxt.chan[k].sc      =
                                io_req.wdata[dcs_pkg::ASSIGN_SC_LSB +: dcs_pkg::SC_W];
                            s_nxt.chan[k].opt_stc = io_req.wdata[dcs_pkg::ASSIGN_STC_BIT];
                            s_nxt.chan[k].opt_clc = io_req.wdata[dcs_pkg::ASSIGN_CLC_BIT];
                        end
                        dcs_pkg::OP_SET_CONTROL: begin
                            s_nxt.chan[k].ctl = 1'b1;
                            if (io_req.clr_flag) begin
                                s_nxt.chan[k].active = 1'b1;
                            end
                        end
                        dcs_pkg::OP_CLEAR_CONTROL: s_nxt.chan[k].ctl = 1'b0;
                        dcs_pkg::OP_SET_FLAG: begin
                            s_nxt.chan[k].flag   = 1'b1;
                            s_nxt.chan[k].active = 1'b0;
                        end
                        dcs_pkg::OP_SKIP_FLAG_SET: s_nxt.io_resp.flag = s_r.chan[k].flag;
                        default: ;
                    endcase
                    if (io_req.clr_flag || io_req.op == dcs_pkg::OP_CLEAR_FLAG) begin
                        s_nxt.chan[k].flag = 1'b0;
                    end
                end
            end
        end

        // Memory port: queued writes first, then an output-direction read
        if (!s_r.mem.req || mem_gnt) begin
            s_nxt.mem.req = 1'b0;
            if (fifo_out_valid) begin
                fifo_out_ready  = 1'b1;
                s_nxt.mem.req   = 1'b1;
                s_nxt.mem.we    = 1'b1;
                s_nxt.mem.addr  = fifo_out_data.addr;
                s_nxt.mem.wdata = fifo_out_data.data;
            end else if (s_r.eng == E_MRD && !s_r.rd_issued) begin
                s_nxt.mem.req   = 1'b1;
                s_nxt.mem.we    = 1'b0;
                s_nxt.mem.addr  = s_r.chan[s_r.cur].addr;
                s_nxt.rd_issued = 1'b1;
            end
        end

        // Word engine, one steal at a time
        c    = s_r.cur;
        ch   = s_r.chan[c];
        last = ch.count == dcs_pkg::COUNT_LAST;
        case (s_r.eng)
            E_IDLE: begin
                if (gnt_valid && req[gnt_ch]) begin
                    s_nxt.cur         = gnt_ch;
                    s_nxt.per_out.sel = 1'b1;
                    s_nxt.per_out.sc  = s_r.chan[gnt_ch].sc;
                    s_nxt.eng         = E_SEL;
                end
            end
            E_SEL: begin
                s_nxt.rd_issued = 1'b0;
                s_nxt.eng       = ch.dir_in ? E_CAP : E_MRD;
            end
            E_CAP: begin
                // A full queue stalls the steal until memory drains it
                if (fifo_in_ready) begin
                    s_nxt.eng = E_CMD;
                end
            end
            E_MRD: begin
                // Leave on the grant edge; read data may come the very next cycle
                if (s_r.rd_issued && s_r.mem.req && mem_gnt) begin
                    s_nxt.eng = E_MWAIT;
                end
            end
            E_MWAIT: begin
                if (mem_rvalid) begin
                    s_nxt.per_out.wr   = 1'b1;
                    s_nxt.per_out.data = mem_rdata;
                    s_nxt.eng          = E_CMD;
                end
            end
            E_CMD: begin
                s_nxt.per_out.sel           = 1'b0;
                s_nxt.per_cmd.valid         = 1'b1;
                s_nxt.per_cmd.sc            = ch.sc;
                s_nxt.per_cmd.clear_flag    = 1'b1;
                s_nxt.per_cmd.set_control   = ch.opt_stc && !(last && ch.dir_in);
                s_nxt.per_cmd.clear_control = last && ch.opt_clc;
                s_nxt.chan[c].addr          = ch.addr + 1'b1;
                s_nxt.chan[c].count         = ch.count + 1'b1;
                if (last) begin
                    s_nxt.chan[c].active = 1'b0;
                    s_nxt.chan[c].flag   = 1'b1;
                end
                s_nxt.eng = E_GAP;
            end
            E_GAP: begin
                // Lets the card flag fall before the next request is seen
                s_nxt.eng = E_IDLE;
            end
            default: s_nxt.eng = E_IDLE;
        endcase

        for (int k = 0; k < dcs_pkg::N_CH; k++) begin
            s_nxt.irq[k] = s_nxt.chan[k].flag && s_nxt.chan[k].ctl;
        end
        s_nxt.irq_loc = s_nxt.irq[0] ? dcs_pkg::IRQ_LOC_CH1 : dcs_pkg::IRQ_LOC_CH2;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign io_resp = s_r.io_resp;
    assign irq_req = s_r.irq;
    assign irq_loc = s_r.irq_loc;
    assign per_out = s_r.per_out;
    assign per_cmd = s_r.per_cmd;
    assign mem_req = s_r.mem;

endmodule
`default_nettype wire

/* tb/dcs_checker.sv */
`default_nettype none
module dcs_checker (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    // Watched ports
    input wire dcs_pkg::dcs_io_req_t  io_req,
    input wire dcs_pkg::dcs_io_resp_t io_resp,
    input wire logic [1:0]            irq_req,
    input wire logic [15:0]           irq_loc,
    input wire dcs_pkg::dcs_per_out_t per_out,
    input wire dcs_pkg::dcs_per_cmd_t per_cmd,
    input wire dcs_pkg::dcs_mem_req_t mem_req,
    input wire logic                  mem_gnt
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    logic foreign;
    assign foreign = io_req.strobe && !(io_req.sc inside {6'h02, 6'h03, 6'h06, 6'h07});

    AST_RESP_NEXT: assert property (io_req.strobe |=> io_resp.valid)
        else $error("no answer one cycle after a strobe");
    AST_RESP_ONLY: assert property (!io_req.strobe |=> !io_resp.valid)
        else $error("answer without a strobe");
    AST_FOREIGN_ZERO: assert property (foreign |=> io_resp.rdata == 16'h0000 && !io_resp.flag)
        else $error("foreign select code answered");
    AST_IRQ_LOC1: assert property (irq_req[0] |-> irq_loc == 16'h0006)
        else $error("wrong location for channel 1");
    AST_IRQ_LOC2: assert property (irq_req == 2'b10 |-> irq_loc == 16'h0007)
        else $error("wrong location for channel 2");
    AST_MEM_HOLD: assert property (mem_req.req && !mem_gnt |=> mem_req.req && $stable(mem_req.addr))
        else $error("memory request dropped before grant");
    AST_CMD_PULSE: assert property (per_cmd.valid |=> !per_cmd.valid)
        else $error("card command longer than one cycle");
    AST_CMD_CLF: assert property (per_cmd.valid |-> per_cmd.clear_flag)
        else $error("card command without clear-flag");
    AST_CMD_CARD: assert property (per_cmd.valid |-> $past(per_out.sel) && per_cmd.sc == $past(per_out.sc))
        else $error("command to a card not being served");

    cover property (per_cmd.valid && per_cmd.clear_control);
    cover property (per_cmd.valid && per_cmd.set_control);
    cover property (irq_req[1]);
    cover property (mem_req.req && !mem_gnt);
endmodule

bind dcs_top dcs_checker u_chk (
    .ref_clk(ref_clk),
    .rst    (rst),
    .io_req (io_req),
    .io_resp(io_resp),
    .irq_req(irq_req),
    .irq_loc(irq_loc),
    .per_out(per_out),
    .per_cmd(per_cmd),
    .mem_req(mem_req),
    .mem_gnt(mem_gnt)
);
`default_nettype wire

/* tb/dcs_partner.sv */
`default_nettype none
module dcs_partner #(
    parameter logic [5:0] CARD_SC = 6'h08
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // Bench controls
    input  wire logic                  start,
    input  wire logic                  stall,
    // Card side
    input  wire dcs_pkg::dcs_per_out_t per_out,
    input  wire dcs_pkg::dcs_per_cmd_t per_cmd,
    output var  logic [63:0]           per_flag,
    output var  logic [15:0]           per_din,
    // Memory side
    input  wire dcs_pkg::dcs_mem_req_t mem_req,
    output var  logic                  mem_gnt,
    output var  logic                  mem_rvalid,
    output var  logic [15:0]           mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        flag;
    logic        busy;
    logic [1:0]  dly;
    logic [15:0] din;
    logic [15:0] rd;
    logic [15:0] mem [0:63];
    logic [15:0] out_w [0:7];
    int          n_out;
    int          n_sc;
    int          n_cc;
    logic        hit;
    assign hit = per_cmd.valid && per_cmd.sc == CARD_SC;
    assign per_flag = 64'(flag) << CARD_SC;
    // Unselected card shows the inverse of its current word, not the word itself
    assign per_din = (per_out.sel && per_out.sc == CARD_SC) ? din : ~din;
    assign mem_gnt = mem_req.req && !stall;
    assign mem_rdata = mem_rvalid ? rd : ~rd;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag <= 1'b0;
            busy <= 1'b0;
            dly <= 2'h0;
            din <= 16'h5a00;
            rd <= 16'h0000;
            mem_rvalid <= 1'b0;
            n_out <= 0;
            n_sc <= 0;
            n_cc <= 0;
        end else begin
            mem_rvalid <= 1'b0;
            if (start || (hit && per_cmd.set_control)) begin
                busy <= 1'b1;
                dly <= 2'h3;
            end else if (busy && dly == 2'h0) begin
                busy <= 1'b0;
                flag <= 1'b1;
            end else if (busy) begin
                dly <= dly - 2'h1;
            end
            if (hit && per_cmd.clear_flag) begin
                flag <= 1'b0;
                din <= din + 16'h0001;
            end
            if (hit && per_cmd.set_control) n_sc <= n_sc + 1;
            if (hit && per_cmd.clear_control) n_cc <= n_cc + 1;
            if (per_out.wr && per_out.sc == CARD_SC && n_out < 8) begin
                out_w[n_out[2:0]] <= per_out.data;
                n_out <= n_out + 1;
            end
            if (mem_req.req && mem_gnt && mem_req.we) mem[mem_req.addr[5:0]] <= mem_req.wdata;
            if (mem_req.req && mem_gnt && !mem_req.we) begin
                mem_rvalid <= 1'b1;
                rd <= mem[mem_req.addr[5:0]];
            end
        end
    end
endmodule
`default_nettype wire

/* tb/dcs_top_test.sv */
`default_nettype none
module dcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk;
    logic                  rst;
    logic                  start;
    logic                  stall;
    dcs_pkg::dcs_io_req_t  io_req;
    dcs_pkg::dcs_io_resp_t io_resp;
    dcs_pkg::dcs_per_out_t per_out;
    dcs_pkg::dcs_per_cmd_t per_cmd;
    dcs_pkg::dcs_mem_req_t mem_req;
    logic [1:0]            irq_req;
    logic [15:0]           irq_loc;
    logic [15:0]           per_din;
    logic [15:0]           mem_rdata;
    logic [15:0]           rd;
    logic [15:0]           r1;
    logic [63:0]           per_flag;
    logic                  mem_gnt;
    logic                  mem_rvalid;
    logic                  fl;
    int                    n_mismatch;
    int                    n_tests;
    int                    cyc;
    int                    sc0;

    dcs_top uut (.ref_clk(ref_clk), .rst(rst), .io_req(io_req), .io_resp(io_resp), .irq_req(irq_req),
        .irq_loc(irq_loc), .per_flag(per_flag), .per_din(per_din), .per_out(per_out), .per_cmd(per_cmd),
        .mem_req(mem_req), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
    dcs_partner far (.ref_clk(ref_clk), .rst(rst), .start(start), .stall(stall), .per_out(per_out),
        .per_cmd(per_cmd), .per_flag(per_flag), .per_din(per_din), .mem_req(mem_req), .mem_gnt(mem_gnt),
        .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic io(input dcs_pkg::dcs_io_op_t op, input logic [5:0] sc, input logic c, input logic [15:0] w);
        @(negedge ref_clk);
        io_req = '{strobe: 1'b1, op: op, sc: sc, clr_flag: c, wdata: w};
        @(negedge ref_clk);
        // Answer stands only in the cycle after the strobe edge
        rd = io_resp.rdata;
        fl = io_resp.flag;
        chk(16'(io_resp.valid), 16'h0001, "answer valid");
        io_req.strobe = 1'b0;
    endtask

    task automatic setup(input logic ch, input logic disc, input logic [15:0] asg, input logic [15:0] adr,
                         input logic [15:0] cnt);
        logic [5:0] su;
        logic [5:0] ct;
        su = ch ? 6'h03 : 6'h02;
        ct = ch ? 6'h07 : 6'h06;
        io(dcs_pkg::OP_OUTPUT_ACC, ct, 1'b0, asg);
        io(dcs_pkg::OP_CLEAR_CONTROL, su, 1'b0, 16'h0000);
        io(dcs_pkg::OP_OUTPUT_ACC, su, 1'b0, adr);
        io(dcs_pkg::OP_SET_CONTROL, su, 1'b0, 16'h0000);
        io(dcs_pkg::OP_OUTPUT_ACC, su, 1'b0, cnt);
        // Disc or drum input needs the channel running before the card starts
        if (disc) io(dcs_pkg::OP_SET_CONTROL, ct, 1'b1, 16'h0000);
        @(negedge ref_clk);
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
        if (!disc) io(dcs_pkg::OP_SET_CONTROL, ct, 1'b1, 16'h0000);
    endtask

    task automatic wait_irq(input int b);
        for (int i = 0; i < 3000 && irq_req[b] !== 1'b1; i++) @(posedge ref_clk);
        // Queued input words still drain to memory after the block ends
        repeat (16) @(negedge ref_clk);
        chk(16'(irq_req[b]), 16'h0001, "block end");
    endtask

    initial begin
        cyc = 0;
        n_mismatch = 0;
        n_tests = 0;
        rst = 1'b1;
        start = 1'b0;
        stall = 1'b0;
        io_req = '0;
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        #1;
        chk({13'h0000, irq_req, mem_req.req}, 16'h0000, "reset outputs");
        // Twelve words in while memory stalls: ten fit in the queue, the eleventh holds its steal until memory drains
        stall = 1'b1;
        setup(1'b0, 1'b0, 16'ha008, 16'h8010, 16'hfff4);
        repeat (200) @(negedge ref_clk);
        stall = 1'b0;
        wait_irq(0);
        chk(irq_loc, 16'h0006, "channel 1 location");
        for (int i = 0; i < 12; i++) chk(far.mem[16 + i], 16'h5a00 + 16'(i), "input word");
        chk(16'(far.n_sc), 16'h000b, "set-control count in");
        chk(16'(far.n_cc), 16'h0001, "clear-control at end");
        io(dcs_pkg::OP_LOAD_INPUT_ACC, 6'h02, 1'b0, 16'h0000);
        chk(rd, 16'h0000, "count at end");
        io(dcs_pkg::OP_SKIP_FLAG_SET, 6'h06, 1'b0, 16'h0000);
        chk(16'(fl), 16'h0001, "channel 1 flag");
        io(dcs_pkg::OP_LOAD_INPUT_ACC, 6'h05, 1'b0, 16'h0000);
        chk(rd, 16'h0000, "foreign code");
        $display("test input block done");
        // Four words out on channel 2, no clear-control option
        io(dcs_pkg::OP_CLEAR_CONTROL, 6'h06, 1'b0, 16'h0000);
        chk(16'(irq_req), 16'h0000, "channel 1 quiet");
        sc0 = far.n_sc;
        setup(1'b1, 1'b0, 16'h8008, 16'h0010, 16'hfffc);
        wait_irq(1);
        chk(irq_loc, 16'h0007, "channel 2 location");
        for (int i = 0; i < 4; i++) chk(far.out_w[i], 16'h5a00 + 16'(i), "output word");
        chk(16'(far.n_sc - sc0), 16'h0004, "set-control count out");
        chk(16'(far.n_cc), 16'h0001, "no clear-control");
        io(dcs_pkg::OP_LOAD_INPUT_ACC, 6'h03, 1'b0, 16'h0000);
        chk(rd, 16'h0000, "channel 2 count");
        $display("test output block done");
        // Disc-order start, aborted at once; count must freeze short of zero
        io(dcs_pkg::OP_CLEAR_CONTROL, 6'h07, 1'b0, 16'h0000);
        setup(1'b0, 1'b1, 16'h8008, 16'h8030, 16'hfff8);
        io(dcs_pkg::OP_SET_FLAG, 6'h06, 1'b0, 16'h0000);
        repeat (40) @(negedge ref_clk);
        io(dcs_pkg::OP_LOAD_INPUT_ACC, 6'h02, 1'b0, 16'h0000);
        r1 = rd;
        repeat (100) @(negedge ref_clk);
        io(dcs_pkg::OP_LOAD_INPUT_ACC, 6'h02, 1'b0, 16'h0000);
        chk(rd, r1, "count after abort");
        chk(16'(r1 == 16'h0000), 16'h0000, "abort stopped early");
        $display("test abort done");
        print_verdict();
    end
endmodule
`default_nettype wire
